// >>> rtl/dcc_consts.svh
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define DCC_ADDR_PORT_A 8'h05
`define DCC_ADDR_INTCTRL 8'h0b
`define DCC_ADDR_PFLAG 8'h0c
`define DCC_ADDR_CMPCTRL 8'h1f
`define DCC_ADDR_PORT_A_DIR 8'h85
`define DCC_ADDR_PENABLE 8'h8c

// ----------------------------------------
// field positions
// ----------------------------------------
`define DCC_CHANGE_FLAG_BIT 6
`define DCC_CMP_IRQ_EN_BIT 6
`define DCC_PERIPH_IRQ_EN_BIT 6
`define DCC_GLOBAL_IRQ_EN_BIT 7
`define DCC_OUT_MSB 7
`define DCC_OUT_LSB 6
`define DCC_MODE_MSB 2
`define DCC_MODE_LSB 0
`define DCC_PIN_FIRST_OUT 3
`define DCC_PIN_SECOND_OUT 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define DCC_RST_MODE 3'h0
`define DCC_RST_DIR 5'h1f
`define DCC_RST_LATCH 5'h00
`define DCC_RST_BYTE 8'h00

// ----------------------------------------
// per-mode table: [7:4] input routing, [3:0] analog pins 3..0
// ----------------------------------------
`define DCC_TBL_RESET 8'h0f
`define DCC_TBL_M1 8'h1f
`define DCC_TBL_M2 8'h2f
`define DCC_TBL_M3 8'h37
`define DCC_TBL_M4 8'h43
`define DCC_TBL_M5 8'h53
`define DCC_TBL_ROUTE 8'h63
`define DCC_TBL_OFF 8'h00

`endif

// >>> rtl/dcc_pkg.sv
package dcc_pkg;

	// comparator mode field encodings
	typedef enum logic [2:0] {
		DCC_MODE_RESET = 3'h0,
		DCC_MODE_1 = 3'h1,
		DCC_MODE_2 = 3'h2,
		DCC_MODE_3 = 3'h3,
		DCC_MODE_4 = 3'h4,
		DCC_MODE_5 = 3'h5,
		DCC_MODE_ROUTE = 3'h6,
		DCC_MODE_OFF = 3'h7
	} dcc_mode_t;

	typedef logic [1:0] dcc_cmp_t;

endpackage : dcc_pkg

// >>> rtl/dcc_cmp_if.sv
`timescale 1ns/1ps

interface dcc_cmp_if;
	dcc_pkg::dcc_cmp_t cmp_level;
	logic relatch;
	dcc_pkg::dcc_cmp_t cmp_sync;
	logic mismatch;

	modport sync_side (
		input cmp_level,
		input relatch,
		output cmp_sync,
		output mismatch
	);

	modport ctrl_side (
		output cmp_level,
		output relatch,
		input cmp_sync,
		input mismatch
	);
endinterface : dcc_cmp_if

// >>> rtl/dcc_cmp_sync.sv
`timescale 1ns/1ps

module dcc_cmp_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// comparator side
	dcc_cmp_if.sync_side cmp
);

	dcc_pkg::dcc_cmp_t meta_ff;
	dcc_pkg::dcc_cmp_t sync_ff;
	dcc_pkg::dcc_cmp_t latched_ff;

	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	// analog levels are asynchronous; stage one feeds stage two only
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_ff <= 2'h0;
			sync_ff <= 2'h0;
		end else begin
			meta_ff <= cmp.cmp_level;
			sync_ff <= meta_ff;
		end
	end

	// ----------------------------------------
	// mismatch latch
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			latched_ff <= 2'h0;
		end else if (cmp.relatch) begin
			latched_ff <= sync_ff;
		end
	end

	assign cmp.cmp_sync = sync_ff;
	assign cmp.mismatch = (sync_ff != latched_ff);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sync_two_stage_a: assert property (
		##2 (sync_ff == $past(cmp.cmp_level, 2)))
		else $error("synchroniser delay is not two cycles");

	relatch_clears_a: assert property (
		cmp.relatch |=> (latched_ff == $past(sync_ff)))
		else $error("relatch did not capture synchronised level");

endmodule : dcc_cmp_sync

// >>> rtl/dcc_ctrl.sv
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "dcc_consts.svh"

// What this block does
// - three-bit mode field picks eight configurations
// - direction register still sets comparator pin direction
// - comparator outputs read-only in bits 7:6
// - mode 110 drives pins 3,4 raw
// - direction bits still gate pins 3,4
// - analog-input pins read zero on port read
// - any output change sets change flag
// - write zero clears flag, one sets it
// - interrupt needs all three enables set
// - control access relatches, ending persistent mismatch
// - change during control read is still flagged
// - comparators run in sleep, change wakes
// - mode 111 powers both comparators off
// - wake-up leaves control register unchanged
// - reset forces mode 000, comparators off
// - comparator wake shows flag bit as one
module dcc_ctrl (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// analog comparators
	input wire logic [1:0] i_cmp_level,
	output logic [1:0] o_cmp_power,
	output logic [3:0] o_cmp_route,
	output logic [3:0] o_analog_sel,
	// port a pins
	input wire logic [4:0] i_pa_in,
	output logic [4:0] o_pa_out,
	output logic [4:0] o_pa_oe,
	// core side
	input wire logic i_sleep,
	output logic o_irq,
	output logic o_wake
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	dcc_pkg::dcc_mode_t mode_ff;
	logic [4:0] dir_ff;
	logic [4:0] latch_ff;
	logic flag_ff;
	logic nxt_flag;
	logic cmp_irq_en_ff;
	logic periph_irq_en_ff;
	logic global_irq_en_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] tbl;
	logic powered;
	logic [1:0] cmp_gated;
	logic [4:0] analog_pins;
	logic [4:0] pin_src;
	logic hit_ctrl;
	logic hit_flag;
	logic hit_en;
	logic hit_intc;
	logic hit_dir;
	logic hit_port;
	logic asleep_ff;

	dcc_cmp_if cmp_if ();

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	assign hit_ctrl = (i_addr == `DCC_ADDR_CMPCTRL);
	assign hit_flag = (i_addr == `DCC_ADDR_PFLAG);
	assign hit_en = (i_addr == `DCC_ADDR_PENABLE);
	assign hit_intc = (i_addr == `DCC_ADDR_INTCTRL);
	assign hit_dir = (i_addr == `DCC_ADDR_PORT_A_DIR);
	assign hit_port = (i_addr == `DCC_ADDR_PORT_A);

	// ----------------------------------------
	// comparator control register
	// ----------------------------------------
	// only the mode field is stored; output bits come live from the synchroniser
	// sleep has no path into this register, so wake-up leaves it intact
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_ff <= dcc_pkg::dcc_mode_t'(`DCC_RST_MODE);
		end else if (i_wr && hit_ctrl) begin
			mode_ff <= dcc_pkg::dcc_mode_t'(i_wdata[`DCC_MODE_MSB:`DCC_MODE_LSB]);
		end
	end

	// ----------------------------------------
	// mode table
	// ----------------------------------------
	always_comb begin
		case (mode_ff)
			dcc_pkg::DCC_MODE_RESET: tbl = `DCC_TBL_RESET;
			dcc_pkg::DCC_MODE_1: tbl = `DCC_TBL_M1;
			dcc_pkg::DCC_MODE_2: tbl = `DCC_TBL_M2;
			dcc_pkg::DCC_MODE_3: tbl = `DCC_TBL_M3;
			dcc_pkg::DCC_MODE_4: tbl = `DCC_TBL_M4;
			dcc_pkg::DCC_MODE_5: tbl = `DCC_TBL_M5;
			dcc_pkg::DCC_MODE_ROUTE: tbl = `DCC_TBL_ROUTE;
			dcc_pkg::DCC_MODE_OFF: tbl = `DCC_TBL_OFF;
			default: tbl = `DCC_TBL_RESET;
		endcase
	end

	// reset mode and off mode both keep the comparators unpowered
	assign powered = (mode_ff != dcc_pkg::DCC_MODE_RESET) &&
		(mode_ff != dcc_pkg::DCC_MODE_OFF);
	assign o_cmp_power = {2{powered}};
	assign o_cmp_route = tbl[7:4];
	assign o_analog_sel = tbl[3:0];
	assign analog_pins = {1'b0, tbl[3:0]};

	// unpowered comparators present a quiet low level
	assign cmp_gated = i_cmp_level & {2{powered}};

	// ----------------------------------------
	// synchroniser and mismatch latch
	// ----------------------------------------
	assign cmp_if.cmp_level = cmp_gated;
	// any control register access relatches; a change in that same cycle is still flagged
	assign cmp_if.relatch = (i_wr || i_rd) && hit_ctrl;

	dcc_cmp_sync u_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.cmp(cmp_if.sync_side)
	);

	// ----------------------------------------
	// change flag
	// ----------------------------------------
	always_comb begin
		nxt_flag = flag_ff;
		if (i_wr && hit_flag) begin
			nxt_flag = i_wdata[`DCC_CHANGE_FLAG_BIT];
		end
		// hardware set beats a software clear in the same cycle
		if (cmp_if.mismatch) begin
			nxt_flag = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// ----------------------------------------
	// interrupt enables
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cmp_irq_en_ff <= 1'b0;
		end else if (i_wr && hit_en) begin
			cmp_irq_en_ff <= i_wdata[`DCC_CMP_IRQ_EN_BIT];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			periph_irq_en_ff <= 1'b0;
			global_irq_en_ff <= 1'b0;
		end else if (i_wr && hit_intc) begin
			periph_irq_en_ff <= i_wdata[`DCC_PERIPH_IRQ_EN_BIT];
			global_irq_en_ff <= i_wdata[`DCC_GLOBAL_IRQ_EN_BIT];
		end
	end

	// flag is set regardless; only the request is gated
	assign o_irq = flag_ff && cmp_irq_en_ff && periph_irq_en_ff && global_irq_en_ff;
	// wake needs only the block's own enable, as a sleeping core services nothing
	assign o_wake = i_sleep && flag_ff && cmp_irq_en_ff;

	// ----------------------------------------
	// sleep tracking
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			asleep_ff <= 1'b0;
		end else begin
			asleep_ff <= i_sleep;
		end
	end

	// ----------------------------------------
	// port a direction and data latch
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dir_ff <= `DCC_RST_DIR;
		end else if (i_wr && hit_dir) begin
			dir_ff <= i_wdata[4:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			latch_ff <= `DCC_RST_LATCH;
		end else if (i_wr && hit_port) begin
			latch_ff <= i_wdata[4:0];
		end
	end

	// ----------------------------------------
	// pin output multiplexers
	// ----------------------------------------
	// routing mode bypasses the synchroniser: pins follow the raw level
	always_comb begin
		pin_src = latch_ff;
		if (mode_ff == dcc_pkg::DCC_MODE_ROUTE) begin
			pin_src[`DCC_PIN_FIRST_OUT] = cmp_gated[0];
			pin_src[`DCC_PIN_SECOND_OUT] = cmp_gated[1];
		end
	end

	assign o_pa_out = pin_src;
	// a cleared direction bit enables the driver in every mode
	assign o_pa_oe = ~dir_ff;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb begin
		nxt_rdata = `DCC_RST_BYTE;
		if (i_rd) begin
			case (1'b1)
				hit_ctrl: begin
					nxt_rdata[`DCC_OUT_MSB:`DCC_OUT_LSB] = cmp_if.cmp_sync;
					nxt_rdata[`DCC_MODE_MSB:`DCC_MODE_LSB] = mode_ff;
				end
				hit_flag: begin
					nxt_rdata[`DCC_CHANGE_FLAG_BIT] = flag_ff;
				end
				hit_en: begin
					nxt_rdata[`DCC_CMP_IRQ_EN_BIT] = cmp_irq_en_ff;
				end
				hit_intc: begin
					nxt_rdata[`DCC_PERIPH_IRQ_EN_BIT] = periph_irq_en_ff;
					nxt_rdata[`DCC_GLOBAL_IRQ_EN_BIT] = global_irq_en_ff;
				end
				hit_dir: begin
					nxt_rdata[4:0] = dir_ff;
				end
				hit_port: begin
					nxt_rdata[4:0] = i_pa_in & ~analog_pins;
				end
				default: begin
					nxt_rdata = `DCC_RST_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_ff <= `DCC_RST_BYTE;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_rdata = rdata_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	flag_on_mismatch_a: assert property (
		cmp_if.mismatch |=> flag_ff)
		else $error("mismatch did not set change flag");

	flag_write_a: assert property (
		(i_wr && hit_flag && !cmp_if.mismatch) |=>
			(flag_ff == $past(i_wdata[`DCC_CHANGE_FLAG_BIT])))
		else $error("change flag did not follow software write");

	irq_gating_a: assert property (
		o_irq |-> (flag_ff && cmp_irq_en_ff && periph_irq_en_ff && global_irq_en_ff))
		else $error("interrupt raised without all enables");

	mode_write_a: assert property (
		(i_wr && hit_ctrl) |=> (mode_ff == $past(i_wdata[`DCC_MODE_MSB:`DCC_MODE_LSB])))
		else $error("mode field not written");

	status_readonly_a: assert property (
		(i_rd && hit_ctrl) |=>
			(o_rdata[`DCC_OUT_MSB:`DCC_OUT_LSB] == $past(cmp_if.cmp_sync)))
		else $error("comparator bits not read back live");

	route_pins_a: assert property (
		(mode_ff == dcc_pkg::DCC_MODE_ROUTE) |->
			(o_pa_out[`DCC_PIN_SECOND_OUT:`DCC_PIN_FIRST_OUT] == cmp_gated))
		else $error("routing mode does not drive raw levels");

	route_oe_a: assert property (
		(mode_ff == dcc_pkg::DCC_MODE_ROUTE) |->
			(o_pa_oe[`DCC_PIN_SECOND_OUT:`DCC_PIN_FIRST_OUT] ==
			~dir_ff[`DCC_PIN_SECOND_OUT:`DCC_PIN_FIRST_OUT]))
		else $error("routing mode pin enables ignore direction");

	analog_read_a: assert property (
		(i_rd && hit_port) |=> ((o_rdata[4:0] & $past(analog_pins)) == 5'h00))
		else $error("analog pin read non-zero");

	off_mode_a: assert property (
		(mode_ff == dcc_pkg::DCC_MODE_OFF) |-> (o_cmp_power == 2'h0))
		else $error("comparators powered in off mode");

	wake_flag_a: assert property (
		(o_wake && asleep_ff && i_rd && hit_flag) |=> o_rdata[`DCC_CHANGE_FLAG_BIT])
		else $error("wake-up flag reads back as zero");

	relatch_ends_a: assert property (
		cmp_if.relatch |=>
			(cmp_if.mismatch == (cmp_if.cmp_sync != $past(cmp_if.cmp_sync))))
		else $error("control access did not end the mismatch");

	sleep_wake_a: assert property (
		(cmp_if.mismatch && i_sleep && cmp_irq_en_ff) |=>
			(o_wake || !i_sleep || !cmp_irq_en_ff))
		else $error("change in sleep did not raise wake");

	dir_write_a: assert property (
		(i_wr && hit_dir) |=> (o_pa_oe == ~$past(i_wdata[4:0])))
		else $error("direction write did not set pin enables");

	mode_hold_a: assert property (
		!(i_wr && hit_ctrl) |=> $stable(mode_ff))
		else $error("control register changed without a write");

endmodule : dcc_ctrl

// >>> dv/dcc_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_ctrl_tb_top;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [1:0] i_cmp_level = 2'h1;
	logic [4:0] i_pa_in = 5'h00;
	logic i_sleep = 1'b0;
	logic [7:0] o_rdata;
	logic [1:0] o_cmp_power;
	logic [3:0] o_cmp_route;
	logic [3:0] o_analog_sel;
	logic [4:0] o_pa_out;
	logic [4:0] o_pa_oe;
	logic o_irq;
	logic o_wake;
	int num_errors = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'hbcd2;
	logic [7:0] exp_q[$];
	logic rd_pend;
	localparam logic [3:0] route_tbl [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0};
	localparam logic [3:0] analog_tbl [8] = '{4'hf, 4'hf, 4'hf, 4'h7, 4'h3, 4'h3, 4'h3, 4'h0};

	always #5 i_clk = ~i_clk;

	dcc_ctrl dut (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_cmp_level(i_cmp_level),
		.o_cmp_power(o_cmp_power),
		.o_cmp_route(o_cmp_route),
		.o_analog_sel(o_analog_sel),
		.i_pa_in(i_pa_in),
		.o_pa_out(o_pa_out),
		.o_pa_oe(o_pa_oe),
		.i_sleep(i_sleep),
		.o_irq(o_irq),
		.o_wake(o_wake)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
			num_errors++;
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask : idle

	// strobe lowered one edge later, so back-to-back calls leave a gap
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		exp_q.push_back(exp);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask : rd

	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// read-data monitor: data stands one cycle only
	// ----------------------------------------
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_pend <= 1'b0;
		end else begin
			if (rd_pend)
				check(o_rdata, exp_q.pop_front());
			rd_pend <= i_rd;
		end
	end

	initial begin
		idle(5000);
		num_errors++;
		tally_and_finish();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic pw;
		repeat (4) @(posedge i_clk);
		check({4'h0, o_analog_sel}, 8'h0f);
		check({6'h0, o_cmp_power}, 8'h00);
		i_arst_n <= 1'b1;
		check({3'h0, o_pa_oe}, 8'h00);
		rd(`DCC_ADDR_CMPCTRL, 8'h00);
		rd(`DCC_ADDR_PORT_A_DIR, 8'h1f);
		wr(8'h40, 8'hff);
		rd(8'h40, 8'h00);
		// every mode, with writes to the read-only output bits
		for (int m = 0; m < 8; m++) begin
			wr(`DCC_ADDR_CMPCTRL, {5'b11000, m[2:0]});
			idle(4);
			pw = (m >= 1) && (m <= 6);
			check({4'h0, o_analog_sel}, {4'h0, analog_tbl[m]});
			check({4'h0, o_cmp_route}, {4'h0, route_tbl[m]});
			check({6'h0, o_cmp_power}, pw ? 8'h03 : 8'h00);
			seed = lfsr_next(seed);
			i_pa_in <= seed[4:0];
			rd(`DCC_ADDR_PORT_A, {3'h0, seed[4:0] & ~{1'b0, analog_tbl[m]}});
			rd(`DCC_ADDR_CMPCTRL, {1'b0, pw, 3'h0, m[2:0]});
		end
		// raw outputs on pins 3,4, gated by direction
		wr(`DCC_ADDR_CMPCTRL, 8'h06);
		wr(`DCC_ADDR_PORT_A_DIR, 8'h07);
		seed = lfsr_next(seed);
		wr(`DCC_ADDR_PORT_A, seed[7:0]);
		i_cmp_level <= 2'h2;
		idle(2);
		check({3'h0, o_pa_oe}, 8'h18);
		check({3'h0, o_pa_out}, {3'h0, 2'b10, seed[2:0]});
		wr(`DCC_ADDR_PORT_A_DIR, 8'h1f);
		idle(1);
		check({3'h0, o_pa_oe}, 8'h00);
		// change flag and mismatch; enables off across mode change
		wr(`DCC_ADDR_CMPCTRL, 8'h01);
		idle(4);
		rd(`DCC_ADDR_CMPCTRL, 8'h81);
		idle(1);
		wr(`DCC_ADDR_PFLAG, 8'h00);
		wr(`DCC_ADDR_INTCTRL, 8'hc0);
		wr(`DCC_ADDR_PENABLE, 8'h40);
		idle(1);
		check({7'h0, o_irq}, 8'h00);
		i_cmp_level <= 2'h3;
		idle(5);
		check({7'h0, o_irq}, 8'h01);
		rd(`DCC_ADDR_PFLAG, 8'h40);
		wr(`DCC_ADDR_PFLAG, 8'h00);
		idle(1);
		check({7'h0, o_irq}, 8'h01);
		rd(`DCC_ADDR_CMPCTRL, 8'hc1);
		idle(1);
		wr(`DCC_ADDR_PFLAG, 8'h00);
		idle(1);
		check({7'h0, o_irq}, 8'h00);
		// software-set flag through every enable combination
		wr(`DCC_ADDR_PFLAG, 8'h40);
		for (int k = 0; k < 8; k++) begin
			wr(`DCC_ADDR_INTCTRL, {k[2], k[1], 6'h0});
			wr(`DCC_ADDR_PENABLE, {1'b0, k[0], 6'h0});
			idle(1);
			check({7'h0, o_irq}, {7'h0, (k == 7)});
		end
		rd(`DCC_ADDR_PFLAG, 8'h40);
		// sleep and wake-up
		i_sleep <= 1'b1;
		idle(1);
		check({7'h0, o_wake}, 8'h01);
		wr(`DCC_ADDR_PFLAG, 8'h00);
		idle(1);
		check({7'h0, o_wake}, 8'h00);
		i_cmp_level <= 2'h0;
		idle(5);
		check({7'h0, o_wake}, 8'h01);
		rd(`DCC_ADDR_PFLAG, 8'h40);
		rd(`DCC_ADDR_CMPCTRL, 8'h01);
		i_sleep <= 1'b0;
		// second reset in mid-run
		idle(1);
		i_arst_n <= 1'b0;
		idle(2);
		check({4'h0, o_analog_sel}, 8'h0f);
		check({6'h0, o_cmp_power}, 8'h00);
		check({7'h0, o_irq}, 8'h00);
		i_arst_n <= 1'b1;
		rd(`DCC_ADDR_CMPCTRL, 8'h00);
		rd(`DCC_ADDR_PFLAG, 8'h00);
		idle(2);
		tally_and_finish();
	end
endmodule : dcc_ctrl_tb_top
